// ### chain_partner.sv
`timescale 1ns/1ps

// Upstream chained device plus the shared result bus that it sits on.
module chain_partner
  import mixer_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic run, // High lets the chain word move on.
  input wire logic [WORD_W-1:0] resultData, // Block result register.
  input wire logic resultOeN, // Low while the block drives the bus.
  output logic [CHAIN_W-1:0] chainIn, // Signed chain word to the block.
  output logic chainInputHoldN, // High marks the word as not offered.
  output logic [WORD_W-1:0] busLevel // Resolved result bus level.
);
  logic [CHAIN_W-1:0] wordFf = 16'h8001;
  logic holdFf = 1'b0;
  logic [1:0] phaseFf = 2'h0;
  logic [WORD_W-1:0] lastDriven = 16'h0000;

  // A new word each clock while run is high; every third is withheld so the block must skip it.
  always @(posedge clk) begin
    if (run) begin
      wordFf <= wordFf + 16'h3A5B;
      phaseFf <= (phaseFf == 2'h2) ? 2'h0 : phaseFf + 2'h1;
      holdFf <= (phaseFf == 2'h2);
    end
  end

  assign chainIn = wordFf;
  assign chainInputHoldN = holdFf;

  // No pull on the bus, so a released bus shows the inverse of its last value.
  // The word is taken at the clock so a release on an edge keeps the word
  // that stood up to that edge, not the one launched by it.
  always @(posedge clk) begin
    if (!resultOeN) lastDriven <= resultData;
  end

  assign busLevel = resultOeN ? ~lastDriven : resultData;
endmodule

// ### chained_sum_output_stage.sv
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Behaviour
// [RULE1] Chain bypass high cuts three stages from the chain input path.
// [RULE2] With bypass low and zero delay, result is chain plus products later.
// [RULE3] Chain hold low captures the chain word into the sum.
// [RULE4] Chain hold high ignores the chain input for that cycle.
// [RULE5] Sum-continue low starts a fresh sum, dropping the old total.
// [RULE6] Sum-continue high adds to the running total, rounding suppressed.
// [RULE7] Rounding without continue adds one at accumulator bit seven.
// [RULE8] Accumulator is 24 bits; upper word 23..8, lower word 15..0.
// [RULE9] Word-select high presents the upper word each clock.
// [RULE10] Word-select low toggles between upper and lower held words.
// [RULE11] While word-select is low, no new results enter the output.
// [RULE12] Active-low drive enable acts asynchronously on the result bus.
// [RULE13] Operands are 12-bit signed; chain word weighted from bit eight.
// [RULE14] Four-bit delay select gives one to sixteen clocks of delay.
// [RULE15] Each operand line advances only while its hold input is low.
// [RULE16] Product invert controls subtract products and skip delay selects.
// [RULE17] Rounding only applies in the first cycle of an accumulation.
// [RULE18] Accumulator and outputs update every rising edge, no reset; the output registers here are cleared by rst.
module chained_sum_output_stage
  import mixer_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [BUS_ADDR_W-1:0] address, // Avalon byte address.
  input wire logic read, // Avalon read request.
  input wire logic write, // Avalon write request.
  input wire logic [BUS_DATA_W-1:0] writedata, // Avalon write data.
  output logic [BUS_DATA_W-1:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon stall.
  input wire logic [OPERAND_W-1:0] portOne, // First multiplier operand.
  input wire logic [OPERAND_W-1:0] portTwo, // First multiplier coefficient.
  input wire logic [OPERAND_W-1:0] portThree, // Second multiplier operand.
  input wire logic [OPERAND_W-1:0] portFour, // Second multiplier coefficient.
  input wire logic [3:0] portHoldN, // Per-port line hold, low advances.
  input wire logic [CHAIN_W-1:0] chainIn, // Chain word from upstream.
  input wire logic chainInputHoldN, // High ignores the chain word.
  input wire logic firstProductInvert, // Subtract the first product.
  input wire logic secondProductInvert, // Subtract the second product.
  input wire logic roundRequest, // Round the fresh sum to 16 bits.
  input wire logic sumContinue, // Add to the running total.
  input wire logic wordSelect, // High upper word, low toggle mode.
  input wire logic driveEnableN, // Result bus drive, active low.
  output logic [WORD_W-1:0] resultData, // Result bus value.
  output logic resultOeN // Result bus enable, low drives.
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic ackFf;
  logic chainBypassFf;
  logic [15:0] delaySelFf;
  logic [BUS_DATA_W-1:0] readDataFf;
  logic busReq;
  logic busTake;
  logic [BUS_DATA_W-1:0] nxt_readData;
  logic [ACC_W-1:0] accFf;
  logic [WORD_W-1:0] resultFf;
  logic phaseFf;

  // Every access costs one wait state, so read data always comes from a flop.
  assign busReq = read | write;
  assign waitrequest = busReq & ~ackFf;
  assign busTake = busReq & ackFf;
  assign readdata = readDataFf;

  always_ff @(posedge clk) begin
    if (rst) begin
      ackFf <= 1'b0;
    end else begin
      ackFf <= busReq & ~ackFf;
    end
  end

  // Writes take effect only at the edge where waitrequest is low.
  always_ff @(posedge clk) begin
    if (rst) begin
      chainBypassFf <= CTRL_BYPASS_RESET;
      delaySelFf <= DELAY_RESET;
    end else if (busTake && write) begin
      if (address == ADDR_CTRL) begin
        chainBypassFf <= writedata[CTRL_BYPASS_BIT];
      end
      if (address == ADDR_DELAY) begin
        delaySelFf <= writedata[15:0];
      end
    end
  end

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    nxt_readData = '0;
    case (address)
      ADDR_CTRL: nxt_readData[CTRL_BYPASS_BIT] = chainBypassFf;
      ADDR_DELAY: nxt_readData[15:0] = delaySelFf;
      ADDR_ACCUM: nxt_readData[ACC_W-1:0] = accFf;
      ADDR_RESULT: begin
        nxt_readData[WORD_W-1:0] = resultFf;
        nxt_readData[RESULT_PHASE_BIT] = phaseFf;
      end
      default: nxt_readData = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readDataFf <= READ_RESET;
    end else if (read && !ackFf) begin
      readDataFf <= nxt_readData;
    end
  end

  // ----------------------------------------------------------------------
  // Operand delay lines
  // ----------------------------------------------------------------------
  logic [OPERAND_W-1:0] tapOne;
  logic [OPERAND_W-1:0] tapTwo;
  logic [OPERAND_W-1:0] tapThree;
  logic [OPERAND_W-1:0] tapFour;

  delay_pipe lineOne (
    .clk(clk),
    .portHoldN(portHoldN[0]),
    .delaySel(delaySelFf[DELAY_ONE_LSB +: DELAY_SEL_W]),
    .dataIn(portOne),
    .dataOut(tapOne)
  );

  delay_pipe lineTwo (
    .clk(clk),
    .portHoldN(portHoldN[1]),
    .delaySel(delaySelFf[DELAY_TWO_LSB +: DELAY_SEL_W]),
    .dataIn(portTwo),
    .dataOut(tapTwo)
  );

  delay_pipe lineThree (
    .clk(clk),
    .portHoldN(portHoldN[2]),
    .delaySel(delaySelFf[DELAY_THREE_LSB +: DELAY_SEL_W]),
    .dataIn(portThree),
    .dataOut(tapThree)
  );

  delay_pipe lineFour (
    .clk(clk),
    .portHoldN(portHoldN[3]),
    .delaySel(delaySelFf[DELAY_FOUR_LSB +: DELAY_SEL_W]),
    .dataIn(portFour),
    .dataOut(tapFour)
  );

  // ----------------------------------------------------------------------
  // Control alignment
  // ----------------------------------------------------------------------
  // Controls follow a fixed pipe, not the delay selects, so they line up
  // with the data only when every select is zero.
  logic [CTRL_STAGES-1:0] invOnePipeFf;
  logic [CTRL_STAGES-1:0] invTwoPipeFf;
  logic [CTRL_STAGES-1:0] roundPipeFf;
  logic [CTRL_STAGES-1:0] contPipeFf;

  always_ff @(posedge clk) begin
    invOnePipeFf <= {invOnePipeFf[CTRL_STAGES-2:0], firstProductInvert};
    invTwoPipeFf <= {invTwoPipeFf[CTRL_STAGES-2:0], secondProductInvert};
    roundPipeFf <= {roundPipeFf[CTRL_STAGES-2:0], roundRequest};
    contPipeFf <= {contPipeFf[CTRL_STAGES-2:0], sumContinue};
  end

  // ----------------------------------------------------------------------
  // Products and sum
  // ----------------------------------------------------------------------
  logic signed [ACC_W-1:0] prodOneFf;
  logic signed [ACC_W-1:0] prodTwoFf;
  logic signed [ACC_W-1:0] signOneFf;
  logic signed [ACC_W-1:0] signTwoFf;
  logic signed [ACC_W-1:0] prodSumFf;
  logic signed [ACC_W-1:0] chainSumFf;
  logic [ACC_W-1:0] nxt_prodSum;
  logic roundNow;

  // Operands are signed 12-bit values with bit 11 as sign.
  always_ff @(posedge clk) begin
    prodOneFf <= 24'($signed(tapOne)) * 24'($signed(tapTwo)); // RULE13
    prodTwoFf <= 24'($signed(tapThree)) * 24'($signed(tapFour)); // RULE13
  end

  always_ff @(posedge clk) begin
    signOneFf <= invOnePipeFf[INVERT_STAGE] ? -prodOneFf : prodOneFf; // RULE16
    signTwoFf <= invTwoPipeFf[INVERT_STAGE] ? -prodTwoFf : prodTwoFf; // RULE16
  end

  // Rounding belongs to the first cycle of a sequence only, so a continued
  // sum never collects repeated half-LSB offsets.
  assign roundNow = roundPipeFf[ROUND_STAGE] & ~contPipeFf[ROUND_STAGE];
  assign nxt_prodSum = 24'(signOneFf + signTwoFf);

  always_ff @(posedge clk) begin
    if (roundNow) begin // RULE7 RULE17
      prodSumFf <= 24'(nxt_prodSum + ROUND_ADD);
    end else begin
      prodSumFf <= nxt_prodSum;
    end
  end

  // ----------------------------------------------------------------------
  // Chain input path
  // ----------------------------------------------------------------------
  logic [CHAIN_W-1:0] chainPipeFf [CHAIN_STAGES];
  logic [CHAIN_W-1:0] chainFeed;

  always_ff @(posedge clk) begin
    if (!chainInputHoldN) begin
      chainPipeFf[0] <= chainIn; // RULE3
    end else begin
      chainPipeFf[0] <= '0; // RULE4
    end
    for (int i = 1; i < CHAIN_STAGES; i++) begin
      chainPipeFf[i] <= chainPipeFf[i-1];
    end
  end

  // Bypass skips three stages so chained parts add little latency.
  assign chainFeed = chainBypassFf ? chainPipeFf[0] // RULE1
                                   : chainPipeFf[CHAIN_STAGES-1]; // RULE2

  // The chain word carries weights 2^8 to 2^23.
  always_ff @(posedge clk) begin
    chainSumFf <= 24'(prodSumFf + {chainFeed, 8'h00}); // RULE13 RULE2
  end

  // ----------------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------------
  // No reset: sum-continue low is the only way to clear the total.
  always_ff @(posedge clk) begin
    if (contPipeFf[CONTINUE_STAGE]) begin
      accFf <= 24'(accFf + chainSumFf); // RULE6 RULE18
    end else begin
      accFf <= chainSumFf; // RULE5 RULE18
    end
  end

  // ----------------------------------------------------------------------
  // Output double register
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] upperHoldFf;
  logic [WORD_W-1:0] lowerHoldFf;

  // The holds freeze while toggling, so both halves seen belong together.
  always_ff @(posedge clk) begin
    if (rst) begin
      upperHoldFf <= RESULT_RESET;
      lowerHoldFf <= RESULT_RESET;
    end else if (wordSelect) begin
      upperHoldFf <= accFf[ACC_W-1:UPPER_LSB]; // RULE8
      lowerHoldFf <= accFf[WORD_W-1:0]; // RULE8
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resultFf <= RESULT_RESET;
      phaseFf <= 1'b0;
    end else if (wordSelect) begin
      resultFf <= accFf[ACC_W-1:UPPER_LSB]; // RULE9 RULE18
      phaseFf <= 1'b0;
    end else begin
      resultFf <= phaseFf ? upperHoldFf : lowerHoldFf; // RULE10 RULE11
      phaseFf <= ~phaseFf; // RULE10
    end
  end

  // Drive enable bypasses the clock entirely.
  assign resultData = resultFf; // RULE12
  assign resultOeN = driveEnableN; // RULE12

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_bus_wait_once: assert property (@(posedge clk) disable iff (rst)
    (busReq && !ackFf) |-> waitrequest ##1 (busReq -> !waitrequest))
    else $error("Bus answer not after exactly one wait state.");

  a_chain_ignore: assert property (@(posedge clk) // RULE4
    chainInputHoldN |=> chainPipeFf[0] == '0)
    else $error("Held chain word was not ignored.");

  a_chain_capture: assert property (@(posedge clk) // RULE3
    !chainInputHoldN |=> chainPipeFf[0] == $past(chainIn))
    else $error("Chain word was not captured.");

  a_chain_bypass: assert property (@(posedge clk) disable iff (rst) // RULE1
    (chainBypassFf && !chainInputHoldN) ##1 chainBypassFf
    |=> chainSumFf == 24'($past(prodSumFf) + {$past(chainIn, 2), 8'h00}))
    else $error("Bypass path latency wrong.");

  a_invert_sub: assert property (@(posedge clk) // RULE16
    invOnePipeFf[INVERT_STAGE] |=> signOneFf == 24'(-$past(prodOneFf)))
    else $error("First product not subtracted.");

  a_round_add: assert property (@(posedge clk) // RULE7
    roundNow |=> prodSumFf
      == 24'($past(signOneFf) + $past(signTwoFf) + ROUND_ADD))
    else $error("Rounding constant not added.");

  a_round_skip: assert property (@(posedge clk) // RULE6
    contPipeFf[ROUND_STAGE] |=> prodSumFf
      == 24'($past(signOneFf) + $past(signTwoFf)))
    else $error("Rounding applied during accumulation.");

  a_fresh_sum: assert property (@(posedge clk) // RULE5
    !contPipeFf[CONTINUE_STAGE] |=> accFf == $past(chainSumFf))
    else $error("Fresh sum kept old total.");

  a_running_sum: assert property (@(posedge clk) // RULE6
    contPipeFf[CONTINUE_STAGE]
    |=> accFf == 24'($past(accFf) + $past(chainSumFf)))
    else $error("Running total not accumulated.");

  a_upper_word: assert property (@(posedge clk) disable iff (rst) // RULE9
    !rst && wordSelect |=> resultFf == $past(accFf[ACC_W-1:UPPER_LSB]))
    else $error("Upper word not presented.");

  a_toggle_words: assert property (@(posedge clk) disable iff (rst) // RULE10
    !wordSelect ##1 !wordSelect |=> resultFf == $past(resultFf, 2))
    else $error("Toggle mode did not alternate words.");

  a_hold_frozen: assert property (@(posedge clk) disable iff (rst) // RULE11
    !wordSelect |=> upperHoldFf == $past(upperHoldFf)
      && lowerHoldFf == $past(lowerHoldFf))
    else $error("New result loaded while toggling.");

endmodule

// ### chained_sum_output_stage_bench.sv
`timescale 1ns/1ps

module chained_sum_output_stage_bench
  import mixer_pkg::*;
;
  logic clk, rst, read, write, waitrequest, chainRun, chk, byp;
  logic [BUS_ADDR_W-1:0] address;
  logic [BUS_DATA_W-1:0] writedata, readdata, rdVal;
  logic [OPERAND_W-1:0] portOne, portTwo, portThree, portFour;
  logic [3:0] portHoldN;
  logic [CHAIN_W-1:0] chainIn;
  logic chainInputHoldN, firstProductInvert, secondProductInvert;
  logic roundRequest, sumContinue, wordSelect, driveEnableN, resultOeN;
  logic [WORD_W-1:0] resultData, busLevel;
  logic [3:0] dly [4];
  logic [OPERAND_W-1:0] line [4][16];
  logic [ACC_W-1:0] prodQ [8];
  logic [1:0] ctlQ [8];
  logic [CHAIN_W-1:0] chQ [8];
  logic [ACC_W-1:0] expAcc [1024];
  logic [ACC_W-1:0] acc, held;
  int edgeNo = 0;
  int bad_count = 0;
  int n_compared = 0;

  chained_sum_output_stage chained_sum_output_stage_i (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .portOne(portOne), .portTwo(portTwo), .portThree(portThree),
    .portFour(portFour), .portHoldN(portHoldN), .chainIn(chainIn),
    .chainInputHoldN(chainInputHoldN),
    .firstProductInvert(firstProductInvert),
    .secondProductInvert(secondProductInvert),
    .roundRequest(roundRequest), .sumContinue(sumContinue),
    .wordSelect(wordSelect), .driveEnableN(driveEnableN),
    .resultData(resultData), .resultOeN(resultOeN)
  );

  chain_partner chain_partner_i (
    .clk(clk), .run(chainRun), .resultData(resultData),
    .resultOeN(resultOeN), .chainIn(chainIn),
    .chainInputHoldN(chainInputHoldN), .busLevel(busLevel)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("Test %s done: %0d checks, %0d bad", name, n_compared, bad_count);
  endtask

  // One bus cycle; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    for (n = 0; n < 20; n++) begin
      #1;
      if (waitrequest === 1'b0) break;
      @(posedge clk);
    end
    @(posedge clk);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      bad_count++;
      give_verdict();
    end
  endtask

  // Drives one data set per clock, with boundary operands and mixed controls.
  task automatic stream(input int n, input logic [3:0] holdMask);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      portOne <= (i % 7 == 0) ? 12'h800 : 12'(i * 173);
      portTwo <= (i % 7 == 0) ? 12'h800 : 12'(i * 91 + 5);
      portThree <= (i % 6 == 2) ? 12'h7FF : 12'(4095 - i * 59);
      portFour <= 12'(i * 211 + 7);
      portHoldN <= (i % 5 == 1) ? holdMask : 4'h0;
      roundRequest <= i[0];
      sumContinue <= i[1];
      firstProductInvert <= i[2];
      secondProductInvert <= i[3];
    end
  endtask

  // Reference model fed from the sampled ports, so idle clocks stay tracked.
  always @(posedge clk) begin
    logic signed [ACC_W-1:0] p1, p2;
    logic [CHAIN_W-1:0] ch;
    logic [OPERAND_W-1:0] ops [4];
    int k, j;
    k = edgeNo % 8;
    j = (edgeNo + 5) % 8;
    ops = '{portOne, portTwo, portThree, portFour};
    for (int p = 0; p < 4; p++) begin
      if (portHoldN[p] === 1'b0) begin
        for (int s = 15; s > 0; s--) line[p][s] = line[p][s-1];
        line[p][0] = ops[p];
      end
    end
    p1 = $signed(line[0][dly[0]]) * $signed(line[1][dly[1]]);
    p2 = $signed(line[2][dly[2]]) * $signed(line[3][dly[3]]);
    prodQ[k] = (firstProductInvert ? -p1 : p1)
      + (secondProductInvert ? -p2 : p2);
    ctlQ[k] = {roundRequest, sumContinue};
    chQ[k] = chainInputHoldN ? '0 : chainIn;
    // Sums close three clocks late so a bypassed chain word can join them.
    ch = byp ? chQ[k] : chQ[j];
    if (ctlQ[j][0]) acc = acc + prodQ[j] + {ch, 8'h00};
    else acc = prodQ[j] + {ch, 8'h00} + (ctlQ[j][1] ? ROUND_ADD : '0);
    expAcc[(edgeNo + 3) % 1024] = acc;
    #1;
    if (chk) check(resultData, expAcc[edgeNo % 1024][23:8], "sum");
    edgeNo++;
  end

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {read, write, chk, byp, portHoldN, driveEnableN} = '0;
    {firstProductInvert, secondProductInvert, roundRequest, sumContinue} = '0;
    {portOne, portTwo, portThree, portFour, address, writedata} = '0;
    {wordSelect, chainRun} = 2'b11;
    dly = '{default: 4'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(resultData, RESULT_RESET, "reset result");
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b0, ADDR_CTRL, '0);
    check(rdVal, READ_RESET, "ctrl reset");
    bus(1'b0, ADDR_DELAY, '0);
    check(rdVal, READ_RESET, "delay reset");
    bus(1'b0, 4'h2, '0);
    check(rdVal, READ_RESET, "unmapped");
    bus(1'b1, ADDR_DELAY, '0);
    done("registers");
    stream(12, 4'h0);
    chk = 1'b1;
    stream(41, 4'h0);
    chk = 1'b0;
    chainRun <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b0, ADDR_ACCUM, '0);
    check(rdVal[23:0], acc, "accumulator");
    bus(1'b0, ADDR_RESULT, '0);
    check(rdVal[15:0], acc[23:8], "result register");
    chainRun <= 1'b1;
    done("sum");
    bus(1'b1, ADDR_DELAY, 32'h0000F530);
    dly = '{4'h0, 4'h3, 4'h5, 4'hF};
    bus(1'b0, ADDR_DELAY, '0);
    check(rdVal, 32'h0000F530, "delay readback");
    stream(20, 4'b0101);
    chk = 1'b1;
    stream(40, 4'b0101);
    chk = 1'b0;
    bus(1'b1, ADDR_DELAY, '0);
    dly = '{default: 4'h0};
    done("delay");
    bus(1'b1, ADDR_CTRL, 32'h00000001);
    byp = 1'b1;
    stream(12, 4'h0);
    chk = 1'b1;
    stream(30, 4'h0);
    chk = 1'b0;
    bus(1'b1, ADDR_CTRL, '0);
    byp = 1'b0;
    done("bypass");
    stream(12, 4'h0);
    @(posedge clk);
    held = expAcc[edgeNo % 1024];
    wordSelect <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      #2;
      check(resultData, t[0] ? held[23:8] : held[15:0], "toggle");
    end
    @(posedge clk);
    wordSelect <= 1'b1;
    @(posedge clk);
    chk = 1'b1;
    stream(8, 4'h0);
    chk = 1'b0;
    done("toggle");
    @(posedge clk);
    held[15:0] = resultData;
    driveEnableN <= 1'b1;
    #1;
    check(resultOeN, 1'b1, "bus released");
    check(busLevel, 16'(~held[15:0]), "released level");
    @(posedge clk);
    driveEnableN <= 1'b0;
    #1;
    check(resultOeN, 1'b0, "bus driven");
    check(busLevel, resultData, "driven level");
    done("drive enable");
    give_verdict();
  end
endmodule

// ### delay_pipe.sv
`timescale 1ns/1ps

// Selectable-depth operand delay line; a held port freezes the whole line.
module delay_pipe
  import mixer_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic portHoldN, // Low lets the line advance.
  input wire logic [DELAY_SEL_W-1:0] delaySel, // Tap select, 0 is one clock.
  input wire logic [OPERAND_W-1:0] dataIn, // Operand from the port.
  output logic [OPERAND_W-1:0] dataOut // Selected tap.
);

  logic [OPERAND_W-1:0] stageFf [PIPE_DEPTH];

  // ----------------------------------------------------------------------
  // Shift line
  // ----------------------------------------------------------------------
  // The line has no reset; its stages hold unknown values until operands have shifted in.
  always_ff @(posedge clk) begin
    if (!portHoldN) begin // RULE15
      stageFf[0] <= dataIn;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        stageFf[i] <= stageFf[i-1];
      end
    end
  end

  // Code 0000 reads the first stage, 1111 the sixteenth.
  assign dataOut = stageFf[delaySel]; // RULE14

  a_pipe_freeze: assert property (@(posedge clk) // RULE15
    portHoldN |=> (stageFf[0] == $past(stageFf[0]))
    && (stageFf[PIPE_DEPTH-1] == $past(stageFf[PIPE_DEPTH-1])))
    else $error("Held operand line moved.");

  a_pipe_take: assert property (@(posedge clk) // RULE15
    !portHoldN |=> stageFf[0] == $past(dataIn))
    else $error("Enabled operand line did not capture.");

  // The line has no reset, so the shift is only judged once the first
  // stage has held a captured value for one clock.
  a_pipe_shift: assert property (@(posedge clk) // RULE15
    !portHoldN ##1 !portHoldN |=> stageFf[1] == $past(stageFf[0]))
    else $error("Enabled operand line did not advance.");

endmodule

// ### mixer_pkg.sv
package mixer_pkg;

  // ----------------------------------------------------------------------
  // Data path widths and depths
  // ----------------------------------------------------------------------
  localparam int OPERAND_W = 12;
  localparam int CHAIN_W = 16;
  localparam int ACC_W = 24;
  localparam int WORD_W = 16;
  localparam int DELAY_SEL_W = 4;
  localparam int PIPE_DEPTH = 16;
  localparam int CHAIN_STAGES = 4;
  localparam int CHAIN_SHIFT = 8;
  localparam int UPPER_LSB = 8;
  localparam int CTRL_STAGES = 5;

  // Stage index at which each per-cycle control meets its data.
  localparam int INVERT_STAGE = 1;
  localparam int ROUND_STAGE = 2;
  localparam int CONTINUE_STAGE = 4;

  // Half-LSB of the upper result word.
  localparam logic [23:0] ROUND_ADD = 24'h000080;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------------
  localparam int BUS_ADDR_W = 4;
  localparam int BUS_DATA_W = 32;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DELAY = 4'h4;
  localparam logic [3:0] ADDR_ACCUM = 4'h8;
  localparam logic [3:0] ADDR_RESULT = 4'hC;

  // Field positions.
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int DELAY_ONE_LSB = 0;
  localparam int DELAY_TWO_LSB = 4;
  localparam int DELAY_THREE_LSB = 8;
  localparam int DELAY_FOUR_LSB = 12;
  localparam int RESULT_PHASE_BIT = 16;

  // Values after reset.
  localparam logic CTRL_BYPASS_RESET = 1'b0;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [31:0] READ_RESET = 32'h00000000;

endpackage
